// ==== swp_pkg.sv ====
// Package with the widths and constants of the synchronous SRAM write-port input capture.
package swp_pkg;
  // ==========================================================================
  // Configuration widths.
  // ==========================================================================
  localparam int WIDE_DATA_W   = 36;
  localparam int NARROW_DATA_W = 18;
  localparam int WIDE_ADDR_W   = 20;
  localparam int NARROW_ADDR_W = 21;
  localparam int LANE_W        = 9;
  localparam int WIDE_LANES    = 4;
  localparam int NARROW_LANES  = 2;
  localparam int BURST_WORDS   = 2;
  // ==========================================================================
  // Values after reset.
  // ==========================================================================
  localparam logic RESET_PHASE = 1'h0;
  localparam logic RESET_FLAG  = 1'h0;
  // Phase of the input clock pair: positive edge or negative edge.
  typedef enum logic {SWP_EDGE_POS, SWP_EDGE_NEG} swp_edge_type;
endpackage

// ==== swp_write_port.sv ====
// Write-port input capture: select, shared address, write data and byte selects.
`timescale 1ns/100ps
`default_nettype none
// Contract
// RL1: Write data is sampled on both the positive and negative input clock edges during writes.
// RL2: A low write port select sampled on the positive edge starts a write.
// RL3: A high write port select deselects the write port and its data is ignored.
// RL4: Byte selects are sampled on both edges and only low-selected bytes are stored.
// RL5: Select 0 gates bits 8..0, 1 gates 17..9, 2 gates 26..18 and 3 gates 35..27.
// RL6: Each byte select is captured on the same edge as the data word it qualifies.
// RL7: A high byte select drops that lane of the captured word from the array write.
// RL8: The shared address is read address on the positive edge, write address on the negative.
// RL9: An address sample whose port is deselected starts no array access.
// RL10: The wide form uses 20 address inputs and the narrow form uses 21.
// RL11: A low read port select on the positive edge starts a read, high deselects it.
// RL12: Every access starts on a positive edge; the negative edge only captures inputs.
// RL13: A write burst is two words on successive positive and negative edges at one address.
//
// One system clock carries both input clock phases; edge_phase_in marks which rising
// edge of the input pair this cycle represents, so a positive edge is followed by a
// negative one.
//
// Timing in system clock cycles, with the controller alternating the phase each cycle:
// - A write is taken at a positive-phase edge with the write select low. The first
//   data word and its lane selects are held, and the write is armed.
// - The following negative-phase edge supplies the write address and the second word.
//   The complete burst leaves on the array outputs one cycle later, as a one-cycle
//   write pulse with address, both masked words and both per-bit masks.
// - A read is taken at a positive-phase edge with the read select low; the read start
//   pulse and the read address follow one cycle later.
// - An armed write whose next edge is not a negative phase is dropped without notice;
//   the controller must keep the phases alternating.
// Dropped lanes carry zero data as well as a zero mask, so the array can write the
// whole word under the mask without any stale bits leaking through.
// There is no handshake back to the controller: every request is taken at its edge.
module swp_write_port
  import swp_pkg::*;
#(
  parameter bit WIDE = 1'b1
) (
  // Clock and reset.
  input  wire logic                        ref_clk_in,
  input  wire logic                        rst_in,
  // Input clock phase: low for a positive-clock edge, high for a negative-clock edge.
  input  wire logic                        edge_phase_in,
  // Port selects and shared address.
  input  wire logic                        write_port_select_n_in,
  input  wire logic                        read_port_select_n_in,
  input  wire logic [NARROW_ADDR_W-1:0]    addr_in,
  // Write data and byte selects.
  input  wire logic [WIDE_DATA_W-1:0]      write_data_in,
  input  wire logic [WIDE_LANES-1:0]       byte_write_select_n_in,
  // Read side start.
  output logic                             read_start_out,
  output logic [NARROW_ADDR_W-1:0]         read_addr_out,
  // Array write burst.
  output logic                             array_write_out,
  output logic [NARROW_ADDR_W-1:0]         array_addr_out,
  output logic [BURST_WORDS*WIDE_DATA_W-1:0] array_data_out,
  output logic [BURST_WORDS*WIDE_DATA_W-1:0] array_mask_out
);
  // ==========================================================================
  // Decode.
  // ==========================================================================
  // Expands the active-low lane selects into a per-bit write mask.
  function automatic logic [WIDE_DATA_W-1:0] lane_mask(input logic [WIDE_LANES-1:0] sel_n);
    logic [WIDE_DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < WIDE_LANES; i++) begin
      m[i*LANE_W +: LANE_W] = {LANE_W{~sel_n[i]}};
    end
    return m;
  endfunction

  localparam int ADDR_W  = WIDE ? WIDE_ADDR_W : NARROW_ADDR_W;
  localparam int LANES   = WIDE ? WIDE_LANES : NARROW_LANES;

  wire logic                     pos_edge;
  wire logic                     neg_edge;
  wire logic [WIDE_LANES-1:0]    lanes_used_n;
  wire logic [WIDE_DATA_W-1:0]   beat_mask;
  wire logic [WIDE_DATA_W-1:0]   beat_data;
  wire logic [NARROW_ADDR_W-1:0] addr_used;

  assign pos_edge  = (edge_phase_in == SWP_EDGE_NEG) ? 1'b0 : 1'b1;
  assign neg_edge  = ~pos_edge;
  // Lanes above the narrow width never write in the narrow form.
  // The narrow form forces lanes two and three off, whatever their select pins show.
  assign lanes_used_n = byte_write_select_n_in
                        | (WIDE ? {WIDE_LANES{1'b0}} : 4'hc);                  // see RL5
  assign beat_mask = lane_mask(lanes_used_n);                                 // see RL4, RL6
  // Dropped lanes are cleared so stale bits never reach the array.
  assign beat_data = write_data_in & beat_mask;                               // see RL7
  // Unused upper address bits are forced to zero.
  assign addr_used = addr_in & NARROW_ADDR_W'((1 << ADDR_W) - 1);              // see RL10

  // ==========================================================================
  // State.
  // ==========================================================================
  logic                       wr_armed_reg;
  logic [WIDE_DATA_W-1:0]     first_data_reg;
  logic [WIDE_DATA_W-1:0]     first_mask_reg;
  logic                       wr_armed_next;

  // A write arms on a positive edge with the select low; the next negative edge completes it.
  assign wr_armed_next = pos_edge & ~write_port_select_n_in;                  // see RL2, RL3, RL12

  // First beat capture on the positive edge.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wr_armed_reg   <= RESET_FLAG;
      first_data_reg <= '0;
      first_mask_reg <= '0;
    end else begin
      wr_armed_reg <= wr_armed_next;
      if (wr_armed_next) begin
        first_data_reg <= beat_data;                                          // see RL1, RL13
        first_mask_reg <= beat_mask;
      end
    end
  end

  // Second beat and write address on the negative edge issue the array write.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      array_write_out <= RESET_FLAG;
      array_addr_out  <= '0;
      array_data_out  <= '0;
      array_mask_out  <= '0;
    end else begin
      array_write_out <= neg_edge & wr_armed_reg;                             // see RL9
      if (neg_edge && wr_armed_reg) begin
        array_addr_out <= addr_used;                                          // see RL8
        array_data_out <= {beat_data, first_data_reg};                        // see RL1, RL13
        array_mask_out <= {beat_mask, first_mask_reg};                        // see RL6
      end
    end
  end

  // Read start and read address on the positive edge.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      read_start_out <= RESET_FLAG;
      read_addr_out  <= '0;
    end else begin
      read_start_out <= pos_edge & ~read_port_select_n_in;                    // see RL11, RL12
      if (pos_edge && !read_port_select_n_in) begin
        read_addr_out <= addr_used;                                           // see RL8, RL9
      end
    end
  end

  // ==========================================================================
  // Checks.
  // ==========================================================================
  write_needs_pos_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL2
    array_write_out |-> $past(pos_edge, 2) && !$past(write_port_select_n_in, 2))
    else $error("Array write without a selected positive edge.");
  deselect_no_write_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL3
    (pos_edge && write_port_select_n_in) |-> ##2 !array_write_out)
    else $error("Deselected write port produced a write.");
  write_on_neg_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL12
    $rose(array_write_out) |-> $past(neg_edge))
    else $error("Array write not completed on a negative edge.");
  mask_data_tie_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL7
    array_write_out |-> ((array_data_out & ~array_mask_out) == '0))
    else $error("Dropped byte lane carried data.");
  lane_mask_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL5
    (neg_edge && wr_armed_reg) |=> array_mask_out[WIDE_DATA_W +: LANE_W]
      == {LANE_W{~$past(byte_write_select_n_in[0])}})
    else $error("Lane zero mask does not follow select zero.");
  write_addr_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL8
    (neg_edge && wr_armed_reg) |=> array_addr_out == $past(addr_used))
    else $error("Write address not taken on the negative edge.");
  first_beat_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL13
    (pos_edge && !write_port_select_n_in) ##1 neg_edge
      |=> array_data_out[WIDE_DATA_W-1:0] == $past(first_data_reg))
    else $error("First burst word lost.");
  read_start_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL11
    read_start_out |-> $past(pos_edge) && !$past(read_port_select_n_in))
    else $error("Read started without a selected positive edge.");

  // Address and read checks: the read port keeps its own sample, unused high bits stay clear, and reads start only when selected on a positive edge.
  read_addr_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL8
    read_start_out |-> read_addr_out == $past(addr_used))
    else $error("Read address not taken on the positive edge.");
  addr_range_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL10
    array_write_out |-> (array_addr_out & ~NARROW_ADDR_W'((1 << ADDR_W) - 1)) == '0)
    else $error("Write address uses more inputs than the form allows.");
  read_deselect_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL9
    (pos_edge && read_port_select_n_in) |=> !read_start_out)
    else $error("Deselected read port started a read.");
  read_neg_idle_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL12
    neg_edge |=> !read_start_out)
    else $error("Read started from a negative edge.");

  // Burst checks: the write is a single pulse and each word keeps its own lanes.
  write_pulse_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL13
    array_write_out |=> !array_write_out)
    else $error("Array write pulse lasted more than one cycle.");
  armed_pos_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL2
    wr_armed_reg |-> $past(pos_edge) && !$past(write_port_select_n_in))
    else $error("Write armed without a selected positive edge.");
  first_lane_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL4
    array_write_out |-> array_mask_out[LANE_W-1:0]
      == {LANE_W{~$past(byte_write_select_n_in[0], 2)}})
    else $error("First word lane zero mask does not follow its select.");
  second_data_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL1
    (neg_edge && wr_armed_reg) |=> array_data_out[2*WIDE_DATA_W-1:WIDE_DATA_W]
      == $past(beat_data))
    else $error("Second burst word not taken on the negative edge.");

  // Hold checks: without a completed burst the array mask and data outputs keep their values.
  mask_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL6
    !(neg_edge && wr_armed_reg) |=> $stable(array_mask_out))
    else $error("Write mask changed without a burst.");
  data_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RL3
    !(neg_edge && wr_armed_reg) |=> $stable(array_data_out))
    else $error("Write data changed without a burst.");
endmodule
`default_nettype wire

// ==== swp_ctrl_model.sv ====
// Controller model that drives random bursts and reads, noting each expected result.
`timescale 1ns/100ps
`default_nettype none
module swp_ctrl_model
  import swp_pkg::*;
(
  // Clock and enable.
  input  wire logic                     clk_in,
  input  wire logic                     en_in,
  // Driven interface.
  output logic                          phase_out  = 1'h1,
  output logic                          wsel_n_out = 1'h1,
  output logic                          rsel_n_out = 1'h1,
  output logic [NARROW_ADDR_W-1:0]      addr_out   = '0,
  output logic [WIDE_DATA_W-1:0]        data_out   = '0,
  output logic [WIDE_LANES-1:0]         bws_n_out  = '1
);
  logic [165:0] wq[$];
  logic [20:0]  rq[$];
  logic [95:0]  r;
  logic         ph;
  logic         pend = 1'h0;
  logic [71:0]  b0;
  logic [71:0]  b1;
  // Returns a beat as masked data over its per-bit write mask.
  function automatic logic [71:0] beat(input logic [35:0] d, input logic [3:0] b_n);
    logic [35:0] m;
    for (int i = 0; i < WIDE_LANES; i++) m[i*LANE_W +: LANE_W] = {LANE_W{~b_n[i]}};
    return {d & m, m};
  endfunction
  // Each edge draws a new beat; phase 0 may open a burst and phase 1 closes it.
  always @(posedge clk_in) begin
    r = {$urandom, $urandom, $urandom};
    ph = en_in ? ~phase_out : 1'h1;
    b1 = beat(r[58:23], r[62:59]);
    phase_out <= ph;
    wsel_n_out <= ~en_in | (r[0] & r[1]);
    rsel_n_out <= ~en_in | r[2];
    addr_out <= {r[63], r[22:3]};
    data_out <= r[58:23];
    bws_n_out <= r[62:59];
    if (!ph) begin
      pend = ~(r[0] & r[1]);
      b0 = b1;
      if (!r[2]) rq.push_back({1'h0, r[22:3]});
    end else if (pend) begin
      wq.push_back({1'h1, 1'h0, r[22:3], b1[71:36], b0[71:36], b1[35:0], b0[35:0]});
      pend = 1'h0;
    end
  end
endmodule
`default_nettype wire

// ==== tb_sync_sram_write_port_inputs.sv ====
// Self-checking testbench for the write-port input capture.
`timescale 1ns/100ps
`default_nettype none
module tb_sync_sram_write_port_inputs;
  import swp_pkg::*;
  logic                          ref_clk_in = 1'h0;
  logic                          rst_in     = 1'h1;
  logic                          en         = 1'h0;
  wire logic                     ph, wsel_n, rsel_n, rd_start, wr;
  wire logic [NARROW_ADDR_W-1:0] addr, rd_addr, wr_addr;
  wire logic [WIDE_DATA_W-1:0]   data;
  wire logic [WIDE_LANES-1:0]    bws_n;
  wire logic [71:0]              wr_data, wr_mask;
  int                            n_mismatch = 0;
  int                            num_checks = 0;
  logic [187:0]                  e;
  swp_ctrl_model swp_ctrl_model_inst (.clk_in(ref_clk_in), .en_in(en), .phase_out(ph),
    .wsel_n_out(wsel_n), .rsel_n_out(rsel_n), .addr_out(addr), .data_out(data),
    .bws_n_out(bws_n));
  swp_write_port #(.WIDE(1'b1)) swp_write_port_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .edge_phase_in(ph), .write_port_select_n_in(wsel_n), .read_port_select_n_in(rsel_n),
    .addr_in(addr), .write_data_in(data), .byte_write_select_n_in(bws_n),
    .read_start_out(rd_start), .read_addr_out(rd_addr), .array_write_out(wr),
    .array_addr_out(wr_addr), .array_data_out(wr_data), .array_mask_out(wr_mask));
  // Makes the 50 MHz clock.
  always #10 ref_clk_in = ~ref_clk_in;
  // Compares one value with its expectation and counts both outcomes.
  task automatic check(input string name, input logic [187:0] seen, input logic [187:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Takes the oldest note off a queue whenever a pulse appears; an empty queue expects unknown.
  always @(negedge ref_clk_in) begin
    if (!rst_in && rd_start !== 1'h0) begin
      e = swp_ctrl_model_inst.rq.size() ? swp_ctrl_model_inst.rq.pop_front() : 'x;
      check("read", {rd_start, rd_addr}, {1'h1, e[20:0]});
    end
    if (!rst_in && wr !== 1'h0) begin
      e = swp_ctrl_model_inst.wq.size() ? swp_ctrl_model_inst.wq.pop_front() : 'x;
      check("write", {wr, wr_addr, wr_data, wr_mask}, e[165:0]);
    end
  end
  // Cuts a hang short.
  initial begin
    #(2000 * 20);
    n_mismatch++;
    conclude();
  end
  // Main sequence: reset, random traffic, drain.
  initial begin
    void'($urandom(32'h8448a00a));
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    check("reset", {rd_start, wr, rd_addr, wr_addr, wr_data, wr_mask}, '0);
    $display("test reset done");
    @(posedge ref_clk_in);
    rst_in <= 1'h0;
    en <= 1'h1;
    repeat (600) @(posedge ref_clk_in);
    en <= 1'h0;
    repeat (4) @(posedge ref_clk_in);
    check("left", 188'(swp_ctrl_model_inst.wq.size() + swp_ctrl_model_inst.rq.size()), '0);
    $display("test random traffic done");
    conclude();
  end
endmodule
`default_nettype wire
